// *** fidsc_defines.vh ***
`ifndef FIDSC_DEFINES_VH
`define FIDSC_DEFINES_VH
// Opcodes
`define FIDSC_OP_QID      8'h94
`define FIDSC_OP_SID      8'h9f
`define FIDSC_OP_AID      8'h90
`define FIDSC_OP_DID      8'h92
`define FIDSC_OP_SUSP     8'h75
`define FIDSC_OP_RES_A    8'h7a
`define FIDSC_OP_RES_B    8'h30
`define FIDSC_OP_READ     8'h03
`define FIDSC_OP_FREAD    8'h0b
`define FIDSC_OP_DUAL_OUTPUT_READ    8'h3b
`define FIDSC_OP_QUAD_OUTPUT_READ    8'h6b
`define FIDSC_OP_DIOREAD  8'hbb
`define FIDSC_OP_QIOREAD  8'heb
`define FIDSC_OP_SFDP     8'h5a
`define FIDSC_OP_SECRD    8'h48
`define FIDSC_OP_BURST    8'h77
`define FIDSC_OP_WLSET    8'h06
`define FIDSC_OP_PW       8'h02
`define FIDSC_OP_DPW      8'ha2
`define FIDSC_OP_QPW      8'h32
`define FIDSC_OP_WRDIS    8'h04
`define FIDSC_OP_STAT     8'h05
`define FIDSC_OP_STAT2    8'h35
`define FIDSC_OP_ASI      8'h25
`define FIDSC_OP_SIG      8'hab
`define FIDSC_OP_RSTARM   8'h66
`define FIDSC_OP_RSTEXE   8'h99
`define FIDSC_OP_NOP      8'h00
// Address byte selecting order
`define FIDSC_ADDR_MFR1ST 8'h00
`define FIDSC_ADDR_DEV1ST 8'h01
// Status bit positions
`define FIDSC_ST_PSUS     15
`define FIDSC_ST_ESUS     10
`define FIDSC_ST_WEL      1
`define FIDSC_ST_WIP      0
// Latencies in ns, clock period in ns
`define FIDSC_CLK_NS      5
`define FIDSC_PSL_NS      30000
`define FIDSC_ESL_NS      30000
`define FIDSC_PSL_CYC     ((`FIDSC_PSL_NS + `FIDSC_CLK_NS - 1) / `FIDSC_CLK_NS)
`define FIDSC_ESL_CYC     ((`FIDSC_ESL_NS + `FIDSC_CLK_NS - 1) / `FIDSC_CLK_NS)
`endif

// *** fidsc_flash_id_susp.v ***
`timescale 1ns/10ps
`include "fidsc_defines.vh"
// Notes on behaviour
// - Quad ID out four lines, MSB first, falling
// - Address 01h gives device code first
// - Address 00h gives manufacturer code first
// - Codes alternate until chip select rises
// - Standard ID shifts 24 bits on one line
// - Chip select high aborts standard ID output
// - Standard ID not decoded during program/erase
// - Suspend interrupts page program or erase
// - Reads blocked only in the suspended region
// - After latency clear latch, set suspend flag
// - Status, security, reset commands skip latency
// - Status bit 15 program, 10 erase suspend
// - Resume clears the set suspend flag
// - Reads, IDs, table, resume allowed when suspended
// - Latch set and page writes erase-suspend only
// - Resume sets latch and busy, clears flag
module fidsc_flash_id_susp #(
  parameter [7:0]  MFR_ID  = 8'h5a, // Arbitrary identity value
  parameter [7:0]  DEV_ID  = 8'h3c, // Arbitrary identity value
  parameter [7:0]  MEM_TYP = 8'h4d, // Arbitrary identity value
  parameter [7:0]  MEM_DEN = 8'h2e, // Arbitrary identity value
  parameter [15:0] PSL_CYC = `FIDSC_PSL_CYC,
  parameter [15:0] ESL_CYC = `FIDSC_ESL_CYC
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // Serial pins
  input  wire        chipSelN,
  input  wire        serialClk,
  input  wire [3:0]  ioLineIn,
  output reg  [3:0]  ioLineOut,
  output reg  [3:0]  ioLineOe,
  // Array engine state
  input  wire        opBusy,
  input  wire        opIsErase,
  input  wire [1:0]  opRegionSize,
  input  wire [23:0] opAddr,
  input  wire        opDone,
  input  wire [23:0] rdAddr,
  // Controls to array engine
  output reg         opHold,
  output reg         cmdAccept,
  output reg  [7:0]  cmdCode,
  output reg         rdAddrOk,
  // Status bits
  output reg  [15:0] statusWord
);
  // Command states
  localparam [2:0] S_OPC  = 3'd0;
  localparam [2:0] S_QADR = 3'd1;
  localparam [2:0] S_QOUT = 3'd2;
  localparam [2:0] S_SOUT = 3'd3;
  localparam [2:0] S_SKIP = 3'd4;

  // Synchronised pin views; select travels inverted so reset reads idle
  wire [5:0] pinSync;
  wire       csN = ~pinSync[5];
  wire       sck = pinSync[4];
  wire [3:0] sio = pinSync[3:0];

  // Pin synchroniser
  fidsc_sync #(.W(6)) uSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     ({~chipSelN, serialClk, ioLineIn}),
    .dout    (pinSync)
  );

  // Serial engine registers
  reg  [2:0]  state_r;
  reg         sckDly_r;
  reg  [7:0]  shift_r;
  reg  [4:0]  bitCnt_r;
  reg  [23:0] outWord_r;

  // Suspend bookkeeping
  reg         pSus_r;
  reg         eSus_r;
  reg         wel_r;
  reg         wip_r;
  reg         susPend_r;
  reg         susErase_r;
  reg  [15:0] latCnt_r;
  reg  [1:0]  regSize_r;
  reg  [23:0] regAddr_r;

  // Serial clock edges and the opcode as it shifts in
  wire       rise = sck & ~sckDly_r;
  wire       fall = ~sck & sckDly_r;
  wire [7:0] opcIn = {shift_r[6:0], sio[0]};
  wire       susp = pSus_r | eSus_r;
  wire       inLat = susPend_r;

  // Opcode acceptance while suspended
  reg bothOk;
  reg eraseOk;
  reg latFree;
  always @* begin
    bothOk  = 1'b0;
    eraseOk = 1'b0;
    latFree = 1'b0;
    case (opcIn)
      `FIDSC_OP_READ, `FIDSC_OP_FREAD, `FIDSC_OP_DUAL_OUTPUT_READ, `FIDSC_OP_QUAD_OUTPUT_READ,
      `FIDSC_OP_DIOREAD, `FIDSC_OP_QIOREAD, `FIDSC_OP_SFDP, `FIDSC_OP_SID,
      `FIDSC_OP_AID, `FIDSC_OP_DID, `FIDSC_OP_QID, `FIDSC_OP_SECRD,
      `FIDSC_OP_BURST, `FIDSC_OP_RES_A, `FIDSC_OP_RES_B: bothOk = 1'b1;
      `FIDSC_OP_WLSET, `FIDSC_OP_PW, `FIDSC_OP_DPW, `FIDSC_OP_QPW: eraseOk = 1'b1;
      default: bothOk = 1'b0;
    endcase
    // Opcodes free of the suspend latency
    case (opcIn)
      `FIDSC_OP_WRDIS, `FIDSC_OP_STAT, `FIDSC_OP_STAT2, `FIDSC_OP_ASI,
      `FIDSC_OP_SIG, `FIDSC_OP_RSTARM, `FIDSC_OP_RSTEXE, `FIDSC_OP_NOP,
      `FIDSC_OP_SECRD: latFree = 1'b1;
      default: latFree = 1'b0;
    endcase
  end

  // Accept decision; lists apply while suspended or counting latency
  wire okInSus   = latFree | ((bothOk | (eraseOk & eSus_r)) & ~inLat);
  wire okNow     = susp | inLat ? okInSus : 1'b1;
  wire sidOk     = (opcIn == `FIDSC_OP_SID) && (susp || !(opBusy && !inLat));
  wire sidRefuse = (opcIn == `FIDSC_OP_SID) && !sidOk;

  // Region mask for the suspended operation
  // Programs always block their own page
  reg [23:0] regMask;
  always @* begin
    case (regSize_r)
      2'd0:    regMask = 24'hffff00; // Page
      2'd1:    regMask = 24'hfff000; // 4KB sector
      2'd2:    regMask = 24'hff8000; // 32KB block
      default: regMask = 24'hff0000; // 64KB block
    endcase
  end

  // Serial command engine
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_r   <= S_OPC;
      sckDly_r  <= 1'b0;
      shift_r   <= 8'h00;
      bitCnt_r  <= 5'd0;
      outWord_r <= 24'h000000;
      ioLineOut <= 4'h0;
      ioLineOe  <= 4'h0;
      cmdAccept <= 1'b0;
      cmdCode   <= 8'h00;
    end else begin
      sckDly_r  <= sck;
      cmdAccept <= 1'b0;
      // Select high aborts output and drops any partial byte
      if (csN) begin
        state_r  <= S_OPC;
        bitCnt_r <= 5'd0;
        shift_r  <= 8'h00;
        ioLineOe <= 4'h0;
      end else begin
        case (state_r)
          // Eight rises make an opcode
          S_OPC: if (rise) begin
            shift_r  <= opcIn;
            bitCnt_r <= bitCnt_r + 5'd1;
            if (bitCnt_r == 5'd7) begin
              bitCnt_r <= 5'd0;
              state_r  <= S_SKIP;
              if (okNow && !sidRefuse) begin
                cmdAccept <= 1'b1;
                cmdCode   <= opcIn;
                if (opcIn == `FIDSC_OP_QID)
                  state_r <= S_QADR;
                else if (sidOk) begin
                  state_r   <= S_SOUT;
                  outWord_r <= {MFR_ID, MEM_TYP, MEM_DEN};
                end
              end
            end
          end
          // Six nibbles: two dummy bytes, then the order byte
          S_QADR: if (rise) begin
            shift_r  <= {shift_r[3:0], sio};
            bitCnt_r <= bitCnt_r + 5'd1;
            if (bitCnt_r == 5'd5) begin
              bitCnt_r <= 5'd0;
              state_r  <= S_QOUT;
              if ({shift_r[3:0], sio} == `FIDSC_ADDR_DEV1ST)
                outWord_r <= {DEV_ID, MFR_ID, 8'h00};
              else
                outWord_r <= {MFR_ID, DEV_ID, 8'h00};
            end
          end
          // Both codes on four lines, high nibble first
          S_QOUT: if (fall) begin
            ioLineOe  <= 4'hf;
            ioLineOut <= outWord_r[23:20];
            // Rotate the pair so the codes keep alternating
            outWord_r <= {outWord_r[19:8], outWord_r[23:20], 8'h00};
          end
          // Twenty-four bits on line one, then release
          S_SOUT: if (fall) begin
            ioLineOe  <= 4'h2;
            ioLineOut <= {2'b00, outWord_r[23], 1'b0};
            outWord_r <= {outWord_r[22:0], 1'b0};
            bitCnt_r  <= bitCnt_r + 5'd1;
            if (bitCnt_r == 5'd24) begin
              ioLineOe <= 4'h0;
              state_r  <= S_SKIP;
            end
          end
          default: state_r <= S_SKIP;
        endcase
      end
    end
  end

  // Suspend and resume control
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pSus_r     <= 1'b0;
      eSus_r     <= 1'b0;
      wel_r      <= 1'b0;
      wip_r      <= 1'b0;
      susPend_r  <= 1'b0;
      susErase_r <= 1'b0;
      latCnt_r   <= 16'd0;
      regSize_r  <= 2'd0;
      regAddr_r  <= 24'h000000;
      opHold     <= 1'b0;
    end else begin
      // Busy and latch follow the array while it runs
      if (!susp && !susPend_r) begin
        wip_r <= opBusy;
        if (opDone)
          wel_r <= 1'b0;
      end
      // Latch set and clear commands
      if (cmdAccept && cmdCode == `FIDSC_OP_WLSET)
        wel_r <= 1'b1;
      if (cmdAccept && cmdCode == `FIDSC_OP_WRDIS)
        wel_r <= 1'b0;
      // Suspend entry, then latency count, then resume
      if (cmdAccept && cmdCode == `FIDSC_OP_SUSP && opBusy && !susp && !susPend_r) begin
        susPend_r  <= 1'b1;
        susErase_r <= opIsErase;
        regSize_r  <= opIsErase ? opRegionSize : 2'd0;
        regAddr_r  <= opAddr;
        opHold     <= 1'b1;
        latCnt_r   <= opIsErase ? ESL_CYC : PSL_CYC;
      end else if (susPend_r) begin
        // Latency over: suspended state becomes visible
        if (latCnt_r <= 16'd1) begin
          susPend_r <= 1'b0;
          wel_r     <= 1'b0;
          wip_r     <= 1'b0;
          pSus_r    <= ~susErase_r;
          eSus_r    <= susErase_r;
        end else begin
          latCnt_r <= latCnt_r - 16'd1;
        end
      end else if (cmdAccept && susp && isResumeCode(cmdCode)) begin
        // Resume restarts the held operation at once
        wel_r  <= 1'b1;
        wip_r  <= 1'b1;
        pSus_r <= 1'b0;
        eSus_r <= 1'b0;
        opHold <= 1'b0;
      end
    end
  end

  // Resume opcode as held after acceptance
  function isResumeCode;
    input [7:0] c;
    begin
      isResumeCode = (c == `FIDSC_OP_RES_A) || (c == `FIDSC_OP_RES_B);
    end
  endfunction

  // Read permission and status word
  // Flags show one cycle after the suspend state
  always @(posedge clk_sys) begin
    if (!nrst) begin
      rdAddrOk   <= 1'b1;
      statusWord <= 16'h0000;
    end else begin
      rdAddrOk <= !susp || ((rdAddr & regMask) != (regAddr_r & regMask));
      statusWord <= 16'h0000;
      statusWord[`FIDSC_ST_PSUS] <= pSus_r;
      statusWord[`FIDSC_ST_ESUS] <= eSus_r;
      statusWord[`FIDSC_ST_WEL]  <= wel_r;
      statusWord[`FIDSC_ST_WIP]  <= wip_r;
    end
  end
endmodule // fidsc_flash_id_susp

// *** fidsc_flash_id_susp_assertions.sv ***
`timescale 1ns/10ps
`include "fidsc_defines.vh"
// Checks pin drive, accept pulses and suspend flags
module fidsc_chk #(
  parameter [15:0] PSL_CYC = 16'h0258,
  parameter [15:0] ESL_CYC = 16'h0258
) (
  // Clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // Serial pins
  input wire        chipSelN,
  input wire        serialClk,
  input wire [3:0]  ioLineIn,
  input wire [3:0]  ioLineOut,
  input wire [3:0]  ioLineOe,
  // Array engine
  input wire        opBusy,
  input wire        opIsErase,
  input wire [1:0]  opRegionSize,
  input wire [23:0] opAddr,
  input wire        opDone,
  input wire [23:0] rdAddr,
  input wire        opHold,
  input wire        cmdAccept,
  input wire [7:0]  cmdCode,
  input wire        rdAddrOk,
  input wire [15:0] statusWord
);
  localparam int LAT_MAX = 700;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Either suspend flag
  wire flagAny = statusWord[15] | statusWord[10];

  a_oe_shape: assert property (ioLineOe inside {4'h0, 4'h2, 4'hf})
    else $error("bad output enable pattern");
  a_cs_release: assert property (chipSelN [*6] |-> ioLineOe == 4'h0)
    else $error("lines driven with chip select high");
  a_accept_pulse: assert property (cmdAccept |=> !cmdAccept)
    else $error("accept pulse too long");
  a_code_hold: assert property (!cmdAccept |-> cmdCode == $past(cmdCode))
    else $error("opcode changed without accept");
  a_flags_excl: assert property (!(statusWord[15] && statusWord[10]))
    else $error("both suspend flags set");
  a_flag_hold: assert property (flagAny |-> $past(opHold))
    else $error("suspend flag without hold");
  a_suspend_latency: assert property ($rose(opHold) |-> (!flagAny) [*8] ##[1:LAT_MAX] flagAny)
    else $error("suspend flag timing wrong");
  a_flag_latch: assert property ($rose(flagAny) |-> !statusWord[1])
    else $error("latch not cleared on suspend");
  a_erase_kind: assert property ($rose(statusWord[10]) |-> opIsErase)
    else $error("erase flag for program");
  a_resume_sets: assert property ($fell(flagAny) |-> statusWord[1] && statusWord[0] ##[0:2] !opHold)
    else $error("resume did not restart");
  a_sid_busy: assert property (cmdAccept && cmdCode == `FIDSC_OP_SID |-> !(opBusy && !opHold))
    else $error("standard id taken while busy");
  a_psus_write: assert property (cmdAccept && statusWord[15] |-> !(cmdCode inside {8'h06, 8'h02, 8'ha2, 8'h32}))
    else $error("write taken in program suspend");
endmodule // fidsc_chk

bind fidsc_flash_id_susp fidsc_chk #(.PSL_CYC(PSL_CYC), .ESL_CYC(ESL_CYC)) fidsc_chk_i (
  .clk_sys, .nrst, .chipSelN, .serialClk, .ioLineIn, .ioLineOut, .ioLineOe, .opBusy,
  .opIsErase, .opRegionSize, .opAddr, .opDone, .rdAddr, .opHold, .cmdAccept, .cmdCode,
  .rdAddrOk, .statusWord);

// *** fidsc_flash_id_susp_bench.sv ***
`timescale 1ns/10ps
`include "fidsc_defines.vh"
// ID readout and suspend tests
module fidsc_flash_id_susp_bench;
  localparam [7:0]  MFR = 8'h5a; // Arbitrary identity value
  localparam [7:0]  DEV = 8'h3c; // Arbitrary identity value
  localparam [7:0]  TYP = 8'h4d; // Arbitrary identity value
  localparam [7:0]  DEN = 8'h2e; // Arbitrary identity value
  localparam [15:0] LAT = 16'h0258;
  logic        clk_sys = 1'b0;
  logic        nrst, opBusy, opIsErase, opDone;
  logic [1:0]  opRegionSize;
  logic [23:0] opAddr, rdAddr;
  logic        chipSelN, serialClk, opHold, cmdAccept, rdAddrOk;
  logic [3:0]  ioLineIn, ioLineOut, ioLineOe;
  logic [7:0]  cmdCode;
  logic [15:0] statusWord;
  logic [31:0] got;
  int          mismatches = 0;
  int          n_compared = 0;
  int          nAcc = 0;

  // Design and host
  fidsc_flash_id_susp #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYP(TYP), .MEM_DEN(DEN),
    .PSL_CYC(LAT), .ESL_CYC(LAT)) fidsc_flash_id_susp_i (.clk_sys, .nrst, .chipSelN,
    .serialClk, .ioLineIn, .ioLineOut, .ioLineOe, .opBusy, .opIsErase, .opRegionSize,
    .opAddr, .opDone, .rdAddr, .opHold, .cmdAccept, .cmdCode, .rdAddrOk, .statusWord);
  fidsc_host fidsc_host_i (.chipSelN, .serialClk, .ioLineIn, .ioLineOut);

  // Clock and accept counter
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cmdAccept === 1'b1) nAcc++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] adr, input int nA, input int nO);
    @(posedge clk_sys);
    #1 fidsc_host_i.frame(op, adr, nA, nO, got);
  endtask
  // Bare opcode, checks whether it was taken
  task automatic cmd(input logic [7:0] op, input logic take);
    int n0;
    n0 = nAcc;
    run(op, 8'h00, 0, 0);
    check("accept", nAcc - n0, take);
    if (take) check("opcode", cmdCode, op);
  endtask
  task automatic probe(input logic [23:0] a, input logic exp);
    @(posedge clk_sys);
    #1 rdAddr = a;
    repeat (3) @(posedge clk_sys);
    check("readable", rdAddrOk, exp);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #300000;
    mismatches++;
    wrap_up;
  end
  // Main sequence
  initial begin
    {nrst, opBusy, opIsErase, opDone, opRegionSize, opAddr, rdAddr} = '0;
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1'b1;
    run(`FIDSC_OP_QID, `FIDSC_ADDR_MFR1ST, 6, 8);
    check("quad id", got, {MFR, DEV, MFR, DEV});
    run(`FIDSC_OP_QID, `FIDSC_ADDR_DEV1ST, 6, 4);
    check("quad id swap", got, {16'h0, DEV, MFR});
    run(`FIDSC_OP_SID, 8'h00, 0, 24);
    check("standard id", got, {8'h0, MFR, TYP, DEN});
    run(`FIDSC_OP_SID, 8'h00, 0, 12);
    check("cut id", got, {20'h0, MFR, TYP[7:4]});
    check("released", ioLineOe, 4'h0);
    $display("id tests done");
    @(posedge clk_sys) #1 {opBusy, opIsErase, opRegionSize, opAddr} = {2'b11, 2'h1, 24'h012345};
    cmd(`FIDSC_OP_SID, 1'b0);
    cmd(`FIDSC_OP_SUSP, 1'b1);
    check("hold on", opHold, 1'b1);
    cmd(`FIDSC_OP_STAT, 1'b1);
    cmd(`FIDSC_OP_FREAD, 1'b0);
    repeat (LAT) @(posedge clk_sys);
    check("erase flags", statusWord & 16'h8402, 16'h0400);
    probe(24'h012abc, 1'b0);
    probe(24'h013000, 1'b1);
    cmd(`FIDSC_OP_FREAD, 1'b1);
    cmd(8'hc7, 1'b0);
    check("flags kept", statusWord & 16'h8400, 16'h0400);
    cmd(`FIDSC_OP_WLSET, 1'b1);
    cmd(`FIDSC_OP_RES_A, 1'b1);
    check("erase resumed", statusWord & 16'h8403, 16'h0003);
    check("hold off", opHold, 1'b0);
    $display("erase suspend done");
    @(posedge clk_sys) #1 {opIsErase, opRegionSize, opAddr} = {1'b0, 2'h0, 24'h000100};
    cmd(`FIDSC_OP_SUSP, 1'b1);
    repeat (LAT) @(posedge clk_sys);
    check("program flags", statusWord & 16'h8402, 16'h8000);
    probe(24'h000150, 1'b0);
    probe(24'h000200, 1'b1);
    cmd(`FIDSC_OP_WLSET, 1'b0);
    cmd(`FIDSC_OP_QID, 1'b1);
    cmd(`FIDSC_OP_RES_B, 1'b1);
    check("program resumed", statusWord & 16'h8403, 16'h0003);
    $display("program suspend done");
    wrap_up;
  end
endmodule // fidsc_flash_id_susp_bench

// *** fidsc_host.sv ***
`timescale 1ns/10ps
// Host controller on the serial link, mode 0
module fidsc_host (
  // Serial pins
  output logic       chipSelN,
  output logic       serialClk,
  output logic [3:0] ioLineIn,
  input  wire  [3:0] ioLineOut
);
  // Idle: deselected, clock low
  initial begin
    chipSelN  = 1'b1;
    serialClk = 1'b0;
    ioLineIn  = 4'h0;
  end
  // One clock: drive on fall, sample just before rise
  task automatic tick(input logic [3:0] d, output logic [3:0] q);
    ioLineIn  = d;
    serialClk = 1'b0;
    #62.5;
    q         = ioLineOut;
    serialClk = 1'b1;
    #62.5;
  endtask
  // Opcode, optional quad dummies and address, then capture
  task automatic frame(input logic [7:0] op, input logic [7:0] adr, input int nAdr,
                       input int nOut, output logic [31:0] got);
    logic [3:0] q;
    chipSelN = 1'b0;
    got      = 32'h0;
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, q);
    for (int i = nAdr - 1; i >= 0; i--) tick(i < 2 ? adr[i*4 +: 4] : 4'h0, q);
    for (int i = 0; i < nOut; i++) begin
      tick(i[0] ? 4'h5 : 4'ha, q);
      got = nAdr > 0 ? {got[27:0], q} : {got[30:0], q[1]};
    end
    serialClk = 1'b0;
    #62.5;
    chipSelN = 1'b1;
    #250;
  endtask
endmodule // fidsc_host

// *** fidsc_sync.v ***
`timescale 1ns/10ps
// Two-flop synchroniser per bit
module fidsc_sync #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         nrst,
  // Data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // Both stages, reset to idle levels
  always @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // fidsc_sync
